// *** blt_pkg.sv ***
// shared constants, enums and carriers for the block-transfer engine
package blt_pkg;

  localparam int BEAT_BYTES = 16;
  localparam int BEAT_W     = 128;
  localparam int ADDR_W     = 32;
  localparam int COORD_W    = 12;
  localparam int PITCH_W    = 16;
  localparam int REG_AW     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int NUM_SLOTS  = 5;

  // register byte offsets
  localparam logic [REG_AW-1:0] REG_CLIP_MIN = 8'h00;
  localparam logic [REG_AW-1:0] REG_CLIP_MAX = 8'h04;
  localparam logic [REG_AW-1:0] REG_FG       = 8'h08;
  localparam logic [REG_AW-1:0] REG_BG       = 8'h0C;
  localparam logic [REG_AW-1:0] REG_KEY      = 8'h10;
  localparam logic [REG_AW-1:0] REG_STATUS   = 8'h14;

  // reset values
  localparam logic [31:0] RST_CLIP_MIN = 32'h0000_0000;
  localparam logic [31:0] RST_CLIP_MAX = 32'h0FFF_0FFF;
  localparam logic [31:0] RST_COLOUR   = 32'h0000_0000;

  // read slot numbers
  localparam logic [2:0] SLOT_S_LO = 3'h0;
  localparam logic [2:0] SLOT_S_HI = 3'h1;
  localparam logic [2:0] SLOT_P_LO = 3'h2;
  localparam logic [2:0] SLOT_D    = 3'h4;

  typedef enum logic [1:0] {SRC_MEM = 2'h0, SRC_MONO = 2'h1, SRC_FILL = 2'h2} src_e;
  typedef enum logic [1:0] {TR_OPAQUE = 2'h0, TR_DST_NE = 2'h1, TR_DST_EQ = 2'h2,
                            TR_KEY = 2'h3} trans_e;
  typedef enum logic [1:0] {BPP8 = 2'h0, BPP16 = 2'h1, BPP32 = 2'h2} depth_e;

  typedef struct packed {
    logic [7:0]         rop;
    src_e               src_sel;
    logic               pat_mem;
    trans_e             trans;
    logic               clip_en;
    logic               x_rev;
    logic               y_rev;
    depth_e             depth;
    logic [COORD_W-1:0] width;
    logic [COORD_W-1:0] height;
    logic [COORD_W-1:0] dst_x;
    logic [COORD_W-1:0] dst_y;
    logic [COORD_W-1:0] src_x;
    logic [COORD_W-1:0] src_y;
    logic [ADDR_W-1:0]  dst_base;
    logic [ADDR_W-1:0]  src_base;
    logic [ADDR_W-1:0]  pat_base;
    logic [PITCH_W-1:0] dst_pitch;
    logic [PITCH_W-1:0] src_pitch;
  } cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic [BEAT_W-1:0]     data;
    logic [BEAT_BYTES-1:0] be;
  } wr_s;

endpackage : blt_pkg

// *** blt_fifo.sv ***
// parameterised valid/ready fifo for returning read beats
`timescale 1ns/1ns
module blt_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      cnt;
  logic             push;
  logic             pop;

  // full and empty straight from the count
  assign o_in_ready  = (cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt != '0);
  assign o_out_data  = mem[rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end

  // pointers wrap at depth, depth is a power of two
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= push ? wp + 1'b1 : wp;
      rp  <= pop ? rp + 1'b1 : rp;
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : blt_fifo

// *** blt_engine.sv ***
// 2d block-transfer engine with raster ops, expansion, transparency and clipping
`timescale 1ns/1ns
module blt_engine (
  input  wire logic                           I_CLOCK,
  input  wire logic                           I_RST_B,
  input  wire logic                           I_CMD_VALID,
  output logic                                O_CMD_READY,
  input  wire blt_pkg::cmd_s                  I_CMD,
  output logic                                O_BUSY,
  input  wire logic [blt_pkg::REG_AW-1:0]     I_REG_ADDR,
  input  wire logic [31:0]                    I_REG_WDATA,
  input  wire logic                           I_REG_WR,
  input  wire logic                           I_REG_RD,
  output logic [31:0]                         O_REG_RDATA,
  output logic                                O_RD_REQ,
  output logic [blt_pkg::ADDR_W-1:0]          O_RD_ADDR,
  input  wire logic                           I_RD_GNT,
  input  wire logic                           I_RD_VALID,
  input  wire logic [blt_pkg::BEAT_W-1:0]     I_RD_DATA,
  output logic                                O_RD_READY,
  output logic                                O_WR_REQ,
  output blt_pkg::wr_s                        O_WR,
  input  wire logic                           I_WR_GNT
);
  import blt_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADR  = 5'b00010,
    ST_REQ  = 5'b00100,
    ST_DATA = 5'b01000,
    ST_WR   = 5'b10000
  } state_e;

  // rop bit select: index is {p, s, d}
  function automatic logic [7:0] rop_byte(input logic [7:0] code, input logic [7:0] s,
                                          input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[b] = code[{p[b], s[b], d[b]}];
    end
    return r;
  endfunction : rop_byte

  // a pixel compares equal only if all its bytes do
  function automatic logic pix_eq(input logic [15:0] e, input int k, input logic [1:0] sh);
    logic r;
    r = e[k];
    if (sh != 2'd0) begin
      r = r & e[k ^ 1];
    end
    if (sh == 2'd2) begin
      r = r & e[k ^ 2] & e[k ^ 3];
    end
    return r;
  endfunction : pix_eq

  state_e                 state;
  cmd_s                   cmd;
  logic [2:0]             slot;
  logic [COORD_W-1:0]     yoff;
  logic [ADDR_W-4-1:0]    bx;
  logic [BEAT_W-1:0]      rbuf [4];
  logic [31:0]            clip_min;
  logic [31:0]            clip_max;
  logic [31:0]            fg;
  logic [31:0]            bg;
  logic [31:0]            key;
  logic [15:0]            done_cnt;
  logic                   fv;
  logic [BEAT_W-1:0]      fd;
  logic                   pop;
  logic [BEAT_BYTES-1:0]  wr_in;

  ////////////////////////////////////////////////////////////////////////////
  // row and beat geometry

  logic [1:0]             sh;
  logic [COORD_W-1:0]     ri;
  logic [COORD_W-1:0]     dy;
  logic [COORD_W-1:0]     sy;
  logic [ADDR_W-1:0]      dst_first;
  logic [ADDR_W-1:0]      src_first;
  logic [ADDR_W-1:0]      wbytes;
  logic [ADDR_W-1:0]      fa;
  logic [ADDR_W-1:0]      la;
  logic [ADDR_W-1:0]      dlast;
  logic [ADDR_W-1:0]      beat_a;
  logic [ADDR_W-1:0]      sa;
  logic [ADDR_W+2:0]      mbit0;
  logic signed [ADDR_W-1:0] p0;
  logic                   last_beat;
  logic                   last_row;
  logic                   row_clip;

  assign sh  = cmd.depth;
  // the chosen corner decides the row walk direction
  assign ri  = cmd.y_rev ? cmd.height - COORD_W'(1) - yoff : yoff;
  assign dy  = cmd.dst_y + ri;
  assign sy  = cmd.src_y + ri;
  assign dst_first = cmd.dst_base + ADDR_W'(dy * cmd.dst_pitch)
                   + (ADDR_W'(cmd.dst_x) << sh);
  assign src_first = cmd.src_base + ADDR_W'(sy * cmd.src_pitch)
                   + (ADDR_W'(cmd.src_x) << sh);
  assign wbytes = ADDR_W'(cmd.width) << sh;
  assign dlast  = dst_first + wbytes - ADDR_W'(1);
  assign fa     = {dst_first[ADDR_W-1:4], 4'h0};
  assign la     = {dlast[ADDR_W-1:4], 4'h0};
  // beats walk left or right as the instruction asks
  assign beat_a = cmd.x_rev ? la - {bx, 4'h0} : fa + {bx, 4'h0};
  assign last_beat = (beat_a == (cmd.x_rev ? fa : la));
  assign last_row  = (yoff == cmd.height - COORD_W'(1));
  // source beat pair straddles the destination-aligned window
  assign sa     = beat_a + (src_first - dst_first);
  assign p0     = $signed(beat_a - dst_first) >>> sh;
  // mono source is one bit per pixel, lsb first in each byte
  assign mbit0  = {cmd.src_base + ADDR_W'(sy * cmd.src_pitch), 3'b000}
                + (ADDR_W+3)'(cmd.src_x) + (ADDR_W+3)'(p0);
  assign row_clip = cmd.clip_en && (dy < clip_min[27:16] || dy > clip_max[27:16]);

  ////////////////////////////////////////////////////////////////////////////
  // read slot addresses

  logic [ADDR_W-1:0] slot_base;
  logic [ADDR_W-1:0] pat_row;
  logic              slot_en;

  // tile line stride is eight pixels; shift sum widened so 32bpp does not wrap
  assign pat_row = cmd.pat_base + (ADDR_W'(dy[2:0]) << (3'(sh) + 3'd3));

  always_comb begin
    slot_base = {beat_a[ADDR_W-1:4], 4'h0};
    slot_en   = 1'b1;
    if (slot <= SLOT_S_HI) begin
      slot_base = (cmd.src_sel == SRC_MONO) ? {mbit0[ADDR_W+2:7], 4'h0}
                                            : {sa[ADDR_W-1:4], 4'h0};
      slot_en   = (cmd.src_sel != SRC_FILL);
    end else if (slot < SLOT_D) begin
      slot_base = {pat_row[ADDR_W-1:5], 5'h00};
      slot_en   = cmd.pat_mem;
    end
    if (slot == SLOT_S_HI || slot == SLOT_P_LO + 3'd1) begin
      slot_base = slot_base + ADDR_W'(BEAT_BYTES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-byte datapath, one 128-bit beat at a time

  logic [2*BEAT_W-1:0]   win_s;
  logic [2*BEAT_W-1:0]   win_p;
  logic [BEAT_W-1:0]     res;
  logic [BEAT_BYTES-1:0] inrow;
  logic [BEAT_BYTES-1:0] clip_ok;
  logic [BEAT_BYTES-1:0] e_ds;
  logic [BEAT_BYTES-1:0] e_sk;
  logic [BEAT_BYTES-1:0] be;

  assign win_s = {rbuf[1], rbuf[0]};
  assign win_p = {rbuf[3], rbuf[2]};

  for (genvar k = 0; k < BEAT_BYTES; k++) begin : g_byte
    logic signed [ADDR_W-1:0] rel;
    logic [ADDR_W-1:0]        pk;
    logic [COORD_W-1:0]       px;
    logic [1:0]               bip;
    logic [7:0]               col;
    logic [7:0]               sb;
    logic [7:0]               pb;
    logic [7:0]               db;
    logic [4:0]               pidx;
    logic [7:0]               mb;

    assign rel  = $signed(beat_a + ADDR_W'(k) - dst_first);
    assign pk   = ADDR_W'(rel >>> sh);
    assign px   = cmd.dst_x + pk[COORD_W-1:0];
    assign bip  = rel[1:0] & ~(2'b11 << sh);
    assign mb   = 8'(mbit0[6:0]) + 8'(pk - ADDR_W'(p0));
    assign col  = win_s[mb] ? fg[bip*8 +: 8] : bg[bip*8 +: 8];
    assign pidx = 5'(pat_row[4:0]) + (5'(px[2:0]) << sh) + 5'(bip);
    assign db   = fd[k*8 +: 8];
    assign inrow[k] = !rel[ADDR_W-1] && (ADDR_W'(rel) < wbytes);
    assign clip_ok[k] = !cmd.clip_en || (!row_clip && px >= clip_min[11:0]
                        && px <= clip_max[11:0]);

    always_comb begin
      case (cmd.src_sel)
        SRC_MEM:  sb = win_s[(5'(sa[3:0]) + 5'(k))*8 +: 8];
        SRC_MONO: sb = col;
        default:  sb = fg[bip*8 +: 8];
      endcase
    end

    // tile repeats every eight pixels across the row
    assign pb = cmd.pat_mem ? win_p[pidx*8 +: 8] : fg[bip*8 +: 8];
    assign res[k*8 +: 8] = rop_byte(cmd.rop, sb, pb, db);
    assign e_ds[k] = (sb == db);
    assign e_sk[k] = (sb == key[bip*8 +: 8]);
  end

  for (genvar k = 0; k < BEAT_BYTES; k++) begin : g_keep
    logic keep;
    always_comb begin
      case (cmd.trans)
        TR_DST_NE: keep = !pix_eq(e_ds, k, sh);
        TR_DST_EQ: keep = pix_eq(e_ds, k, sh);
        TR_KEY:    keep = !pix_eq(e_sk, k, sh);
        default:   keep = 1'b1;
      endcase
    end
    assign be[k] = inrow[k] && clip_ok[k] && keep;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data buffer; stalls memory only once all eight entries are full

  blt_fifo #(.WIDTH(BEAT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (I_CLOCK),
    .i_rst_b     (I_RST_B),
    .i_in_valid  (I_RD_VALID),
    .o_in_ready  (O_RD_READY),
    .i_in_data   (I_RD_DATA),
    .o_out_valid (fv),
    .i_out_ready (pop),
    .o_out_data  (fd)
  );

  assign pop = (state == ST_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one instruction at a time, in arrival order

  assign O_CMD_READY = (state == ST_IDLE);
  assign O_BUSY      = !state[0];
  assign O_RD_REQ    = (state == ST_REQ);
  assign O_WR_REQ    = (state == ST_WR);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      state <= ST_IDLE;
      slot  <= '0;
      yoff  <= '0;
      bx    <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (I_CMD_VALID) begin
            state <= ST_ADR;
            slot  <= '0;
            yoff  <= '0;
            bx    <= '0;
          end
        end
        ST_ADR: begin
          if (slot_en) begin
            state <= ST_REQ;
          end else begin
            slot <= slot + 3'd1;
          end
        end
        ST_REQ: begin
          if (I_RD_GNT) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (fv) begin
            state <= (slot == SLOT_D) ? ST_WR : ST_ADR;
            slot  <= slot + 3'd1;
          end
        end
        default: begin
          if (I_WR_GNT) begin
            slot <= '0;
            if (last_beat) begin
              bx   <= '0;
              yoff <= yoff + COORD_W'(1);
            end else begin
              bx <= bx + 1'b1;
            end
            // release right after the final write is taken
            state <= (last_beat && last_row) ? ST_IDLE : ST_ADR;
          end
        end
      endcase
    end
  end

  // instruction latched whole at acceptance
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      cmd <= '0;
    end else if (O_CMD_READY && I_CMD_VALID) begin
      cmd <= I_CMD;
    end
  end

  // read address is registered a cycle ahead of the request
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_RD_ADDR <= '0;
    end else if (state == ST_ADR) begin
      O_RD_ADDR <= slot_base;
    end
  end

  // source and pattern beats parked until the destination arrives
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      for (int i = 0; i < 4; i++) begin
        rbuf[i] <= '0;
      end
    end else if (state == ST_DATA && fv && slot != SLOT_D) begin
      rbuf[slot[1:0]] <= fd;
    end
  end

  // write beat captured with the destination read
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_WR  <= '0;
      wr_in <= '0;
    end else if (state == ST_DATA && fv && slot == SLOT_D) begin
      O_WR.addr <= {beat_a[ADDR_W-1:4], 4'h0};
      O_WR.data <= res;
      O_WR.be   <= be;
      wr_in     <= inrow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port; writes land at once, even mid-transfer

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      clip_min <= RST_CLIP_MIN;
      clip_max <= RST_CLIP_MAX;
      fg       <= RST_COLOUR;
      bg       <= RST_COLOUR;
      key      <= RST_COLOUR;
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == REG_CLIP_MIN) begin
        clip_min <= I_REG_WDATA;
      end else if (I_REG_ADDR == REG_CLIP_MAX) begin
        clip_max <= I_REG_WDATA;
      end else if (I_REG_ADDR == REG_FG) begin
        fg <= I_REG_WDATA;
      end else if (I_REG_ADDR == REG_BG) begin
        bg <= I_REG_WDATA;
      end else if (I_REG_ADDR == REG_KEY) begin
        key <= I_REG_WDATA;
      end
    end
  end

  // completed instruction count, wraps
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      done_cnt <= '0;
    end else if (O_WR_REQ && I_WR_GNT && last_beat && last_row) begin
      done_cnt <= done_cnt + 16'd1;
    end
  end

  // read data valid only the cycle after the strobe; unmapped reads zero
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      O_REG_RDATA <= '0;
    end else if (!I_REG_RD) begin
      O_REG_RDATA <= '0;
    end else if (I_REG_ADDR == REG_CLIP_MIN) begin
      O_REG_RDATA <= clip_min;
    end else if (I_REG_ADDR == REG_CLIP_MAX) begin
      O_REG_RDATA <= clip_max;
    end else if (I_REG_ADDR == REG_FG) begin
      O_REG_RDATA <= fg;
    end else if (I_REG_ADDR == REG_BG) begin
      O_REG_RDATA <= bg;
    end else if (I_REG_ADDR == REG_KEY) begin
      O_REG_RDATA <= key;
    end else if (I_REG_ADDR == REG_STATUS) begin
      O_REG_RDATA <= {done_cnt, 15'h0000, O_BUSY};
    end else begin
      O_REG_RDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);

  a_busy_accept: assert property (O_CMD_READY && I_CMD_VALID |=> O_BUSY [*2])
    else $error("busy not raised after accept");
  a_busy_refuse: assert property (O_BUSY |-> !O_CMD_READY)
    else $error("instruction taken while busy");
  a_last_release: assert property (O_WR_REQ && I_WR_GNT && last_beat && last_row
    |=> !O_BUSY && O_CMD_READY)
    else $error("busy held after last write");
  a_wr_hold: assert property (O_WR_REQ && !I_WR_GNT |=> O_WR_REQ && $stable(O_WR))
    else $error("write beat changed while waiting");
  a_wr_align: assert property (O_WR_REQ |-> O_WR.addr[3:0] == 4'h0)
    else $error("write beat not aligned");
  a_opaque_full: assert property (O_WR_REQ && cmd.trans == TR_OPAQUE && !cmd.clip_en
    |-> O_WR.be == wr_in)
    else $error("opaque write dropped pixels");
  a_row_bound: assert property (O_WR_REQ |-> (O_WR.be & ~wr_in) == '0)
    else $error("write outside rectangle");
  a_clip_row: assert property (state == ST_DATA && fv && slot == SLOT_D && row_clip
    |=> O_WR_REQ && O_WR.be == '0)
    else $error("clipped row written");
  a_rop_ones: assert property (O_WR_REQ && cmd.rop == 8'hFF |-> &O_WR.data)
    else $error("rop ff not all ones");
  a_rop_zero: assert property (O_WR_REQ && cmd.rop == 8'h00 |-> O_WR.data == '0)
    else $error("rop 00 not zero");

  c_rev_copy: cover property (O_CMD_READY && I_CMD_VALID && I_CMD.x_rev && I_CMD.y_rev);
  c_trans_skip: cover property (O_WR_REQ && cmd.trans != TR_OPAQUE && O_WR.be != wr_in);
  c_mono: cover property (O_WR_REQ && cmd.src_sel == SRC_MONO && I_WR_GNT);
  c_fifo_full: cover property (!O_RD_READY);
endmodule : blt_engine

// *** blt_mem_model.sv ***
// memory and read-return partner model facing the block-transfer engine
`timescale 1ns/1ns
module blt_mem_model
  import blt_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_rd_req,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic                   o_rd_gnt,
  output logic                   o_rd_valid,
  output logic [BEAT_W-1:0]      o_rd_data,
  input  wire logic              i_rd_ready,
  input  wire logic              i_wr_req,
  input  wire wr_s               i_wr,
  output logic                   o_wr_gnt
);
  logic [7:0]        mem [0:4095];
  logic [ADDR_W-1:0] pend;
  logic              pending;
  int                seed = 94234;
  ////////////////////////////////////////////////////////////////////////////////
  // random idle cycles before grants and returns, so the engine must wait
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rd_gnt <= 0;
      o_wr_gnt <= 0;
      o_rd_valid <= 0;
      o_rd_data <= '0;
      pending <= 0;
    end else begin
      o_rd_gnt <= i_rd_req && !o_rd_gnt && !pending && ($random(seed) & 3) == 0;
      if (o_rd_gnt && i_rd_req) begin
        pend <= i_rd_addr;
        pending <= 1;
      end
      // one return per granted read, in request order
      if (pending && !o_rd_valid && ($random(seed) & 1)) begin
        for (int k = 0; k < 16; k++) o_rd_data[8*k+:8] <= mem[{pend[11:4], 4'h0} + k];
        o_rd_valid <= 1;
      end
      // released data bus shows the inverse so a stale beat is never mistaken
      if (o_rd_valid && i_rd_ready) begin
        o_rd_valid <= 0;
        pending <= 0;
        o_rd_data <= ~o_rd_data;
      end
      o_wr_gnt <= i_wr_req && !o_wr_gnt && ($random(seed) & 1);
      if (o_wr_gnt && i_wr_req)
        for (int k = 0; k < 16; k++)
          if (i_wr.be[k]) mem[{i_wr.addr[11:4], 4'h0} + k] <= i_wr.data[8*k+:8];
    end
  end
endmodule : blt_mem_model

// *** tb.sv ***
// self-checking bench: random rectangles checked against a byte-level golden image
`timescale 1ns/1ns
module tb;
  import blt_pkg::*;
  logic              clk, rst_b, cmd_valid, cmd_ready, busy, reg_wr, reg_rd;
  logic              rd_req, rd_gnt, rd_valid, rd_ready, wr_req, wr_gnt;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, fg, bg, key, cmin, cmax;
  logic [ADDR_W-1:0] rd_addr;
  logic [BEAT_W-1:0] rd_data;
  cmd_s              cmd;
  wr_s               wr;
  logic [7:0]        img [0:4095];
  logic [7:0]        exp [0:4095];
  int                n_errors, comparisons, seed, cycles;
  blt_engine dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_CMD_VALID(cmd_valid),
    .O_CMD_READY(cmd_ready), .I_CMD(cmd), .O_BUSY(busy), .I_REG_ADDR(reg_addr),
    .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata),
    .O_RD_REQ(rd_req), .O_RD_ADDR(rd_addr), .I_RD_GNT(rd_gnt), .I_RD_VALID(rd_valid),
    .I_RD_DATA(rd_data), .O_RD_READY(rd_ready), .O_WR_REQ(wr_req), .O_WR(wr),
    .I_WR_GNT(wr_gnt));
  blt_mem_model mem_m (.i_clk(clk), .i_rst_b(rst_b), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .o_rd_gnt(rd_gnt), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rd_ready),
    .i_wr_req(wr_req), .i_wr(wr), .o_wr_gnt(wr_gnt));
  ////////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // hang guard, generous against a few thousand cycles of real work
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      finish_test;
    end
  end
  task automatic finish_test;
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic check(logic [31:0] seen, logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask : reg_write
  task automatic reg_read(logic [7:0] a, logic [31:0] want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    check(reg_rdata, want);
  endtask : reg_read
  ////////////////////////////////////////////////////////////////////////////////
  // golden model: per pixel, per byte, from the snapshot taken before the command
  task automatic predict(cmd_s c);
    int nb, dx, dy, da, ba;
    logic [31:0] s, p, d, r, m, w;
    nb = 1 << c.depth;
    m = 32'hFFFF_FFFF >> (32 - 8 * nb);
    for (int y = 0; y < c.height; y++)
      for (int x = 0; x < c.width; x++) begin
        dx = c.dst_x + x;
        dy = c.dst_y + y;
        da = c.dst_base + dy * c.dst_pitch + dx * nb;
        ba = (c.src_base + (c.src_y + y) * c.src_pitch) * 8 + c.src_x + x;
        for (int b = 0; b < nb; b++) begin
          case (c.src_sel)
            SRC_MEM: s[8*b+:8] = img[c.src_base + (c.src_y + y) * c.src_pitch + (c.src_x + x) * nb + b];
            SRC_MONO: s[8*b+:8] = img[ba / 8][ba % 8] ? fg[8*b+:8] : bg[8*b+:8];
            default: s[8*b+:8] = fg[8*b+:8];
          endcase
          p[8*b+:8] = c.pat_mem ? img[c.pat_base + (dy % 8) * 8 * nb + (dx % 8) * nb + b] : fg[8*b+:8];
          d[8*b+:8] = img[da + b];
        end
        for (int i = 0; i < 32; i++) r[i] = c.rop[{p[i], s[i], d[i]}];
        w = ((c.trans == TR_KEY ? key : d) ^ s) & m;
        if ((c.trans == TR_OPAQUE || (c.trans == TR_DST_EQ ? w == 0 : w != 0))
            && !(c.clip_en && (dx < cmin[11:0] || dx > cmax[11:0] || dy < cmin[27:16] || dy > cmax[27:16])))
          for (int b = 0; b < nb; b++) exp[da + b] = r[8*b+:8];
      end
  endtask : predict
  task automatic run(int n);
    cmd_s c;
    int t;
    fg = $random(seed);
    bg = $random(seed);
    key = n[2] ? fg : $random(seed);
    cmin = {16'($random(seed) & 3), 16'($random(seed) & 3)};
    cmax = {16'(3 + ($random(seed) & 15)), 16'(4 + ($random(seed) & 15))};
    reg_write(REG_FG, fg);
    reg_write(REG_BG, bg);
    reg_write(REG_KEY, key);
    reg_write(REG_CLIP_MIN, cmin);
    reg_write(REG_CLIP_MAX, cmax);
    reg_read(REG_CLIP_MAX, cmax);
    c = '0;
    // last two commands pin the all-zero and all-one codes
    c.rop = n < 8 ? 8'hCC : n == 34 ? 8'h00 : n == 35 ? 8'hFF : 8'($random(seed));
    c.src_sel = src_e'(n % 3);
    c.depth = depth_e'((n / 3) % 3);
    c.trans = trans_e'((n / 9) % 4);
    c.pat_mem = n[1];
    c.clip_en = n[2];
    c.width = 12'(1 + ($random(seed) & 7));
    c.height = 12'(1 + ($random(seed) & 3));
    c.dst_x = 12'($random(seed) & 7);
    c.dst_y = 12'($random(seed) & 3);
    c.src_x = 12'($random(seed) & 7);
    c.src_y = 12'($random(seed) & 3);
    c.src_pitch = 64;
    c.dst_pitch = 64;
    c.pat_base = 32'h0000_0400;
    // odd memory-source commands overlap in place; the corner follows the shift
    c.dst_base = (n[0] && c.src_sel == SRC_MEM) ? 32'h0000_0000 : 32'h0000_0800;
    c.x_rev = c.dst_x > c.src_x;
    c.y_rev = c.dst_y > c.src_y;
    for (int i = 0; i < 4096; i++) img[i] = mem_m.mem[i];
    exp = img;
    predict(c);
    @(posedge clk);
    cmd <= c;
    cmd_valid <= 1;
    @(posedge clk);
    cmd_valid <= 0;
    @(negedge clk);
    check(busy, 1);
    check(cmd_ready, 0);
    for (t = 0; t < 5000 && busy !== 1'b0; t++) @(negedge clk);
    check(cmd_ready, 1);
    for (int i = 0; i < 4096; i++) check(mem_m.mem[i], exp[i]);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 94234;
    clk = 0;
    rst_b = 0;
    cmd_valid = 0;
    cmd = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 0;
    reg_rd = 0;
    for (int i = 0; i < 4096; i++) mem_m.mem[i] = 8'($random(seed));
    repeat (6) @(posedge clk);
    rst_b <= 1;
    reg_read(REG_CLIP_MAX, RST_CLIP_MAX);
    reg_read(REG_CLIP_MIN, RST_CLIP_MIN);
    reg_read(REG_BG, RST_COLOUR);
    reg_write(REG_STATUS, 32'hFFFF_FFFF);
    reg_write(8'h18, 32'hFFFF_FFFF);
    reg_read(8'h18, 32'h0000_0000);
    reg_read(REG_STATUS, 32'h0000_0000);
    for (int n = 0; n < 36; n++) run(n);
    reg_read(REG_STATUS, 32'h0024_0000);
    finish_test;
  end
endmodule : tb
